// >>> hw/scr_pkg.sv
// Purpose: shared constants and types for the sensor status and configuration register bank
// Assumes: 8-bit register addresses and 8-bit register data on the internal register port
// Notes: the serial bus engine decodes the two-wire protocol and hands single accesses here

package scr_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_SAMPLE_STATUS = 8'h00;
  localparam logic [7:0] ADDR_X_HIGH = 8'h01;
  localparam logic [7:0] ADDR_Y_HIGH = 8'h03;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h05;
  localparam logic [7:0] ADDR_SYSTEM_MODE = 8'h0b;
  localparam logic [7:0] ADDR_INT_SOURCE = 8'h0c;
  localparam logic [7:0] ADDR_IDENTITY = 8'h0d;
  localparam logic [7:0] ADDR_RANGE_CONFIG = 8'h0e;
  localparam logic [7:0] ADDR_FILTER_CUTOFF = 8'h0f;
  localparam logic [7:0] ADDR_ORIENT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FALL_MOTION_SRC = 8'h20;
  localparam logic [7:0] ADDR_TRANSIENT_SRC = 8'h21;
  localparam logic [7:0] ADDR_TAP_SRC = 8'h22;

  // ************************************************************
  // field layout and reset values
  // ************************************************************
  localparam int SRC_SLEEP_WAKE_BIT = 7;
  localparam int SRC_TRANSIENT_BIT = 5;
  localparam int SRC_ORIENT_BIT = 4;
  localparam int SRC_TAP_BIT = 3;
  localparam int SRC_FALL_MOTION_BIT = 2;
  localparam int SRC_SAMPLE_READY_BIT = 0;
  localparam logic [7:0] SRC_USED_MASK = 8'hbd;
  localparam int TAP_HPF_BYPASS_BIT = 5;
  localparam int TAP_LPF_ENABLE_BIT = 4;
  localparam logic [7:0] FILTER_USED_MASK = 8'h33;
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] FS_2G = 2'h0;
  localparam logic [7:0] FILTER_RESET = 8'h00;
  localparam logic [5:0] ZERO_FILL = 6'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_WAKE = 3'b010,
    ST_SLEEP = 3'b100
  } scr_mode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scr_req_t;

  typedef struct packed {
    logic transient_ea;
    logic orientation_changed;
    logic tap_ea;
    logic fall_motion_ea;
    logic all_axes_ready;
    logic all_axes_overrun;
    logic wake_event;
  } scr_events_t;

  typedef struct packed {
    logic sleep_wake;
    logic transient;
    logic orientation;
    logic tap;
    logic fall_motion;
    logic sample_ready;
  } scr_int_en_t;

endpackage

// >>> hw/scr_regs.sv
// Purpose: system mode, interrupt source, identity, range and filter registers
// Assumes: register port and event inputs come from logic on core_clk_i, so no synchronisers
// Notes: source flags are sticky and cleared by reads of the owning source registers, sample ready by reads of all three axis high bytes

module scr_regs #(
  parameter logic [7:0] IDENTITY_CODE = 8'h5c, // arbitrary value, stands in for the factory part code
  parameter int IDLE_TICK_CYCLES = 40000 // cycles per idle-limit step
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire scr_pkg::scr_req_t req_i,
  input wire scr_pkg::scr_events_t events_i,
  input wire scr_pkg::scr_int_en_t int_en_i,
  input wire logic active_i,
  input wire logic auto_sleep_en_i,
  input wire logic [7:0] sleep_idle_limit_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [1:0] mode_o,
  output logic low_rate_sel_o,
  output logic [7:0] int_source_o,
  output logic [1:0] full_scale_o,
  output logic tap_hpf_bypass_o,
  output logic tap_lpf_en_o,
  output logic [1:0] cutoff_sel_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    scr_pkg::scr_mode_t mode;
    logic [1:0] mode_field;
    logic low_rate;
    logic [7:0] src;
    logic [7:0] cond_prev;
    logic wake_prev;
    logic [2:0] axes_read;
    logic [7:0] idle_cnt;
    logic [15:0] tick_cnt;
    logic [1:0] full_scale;
    logic [7:0] filter;
    logic [7:0] rdata;
    logic rvalid;
  } scr_state_t;

  localparam scr_state_t STATE_RESET = '{
    mode: scr_pkg::ST_STANDBY,
    mode_field: scr_pkg::MODE_STANDBY,
    low_rate: 1'b0,
    src: 8'h00,
    cond_prev: 8'h00,
    wake_prev: 1'b0,
    axes_read: 3'h0,
    idle_cnt: 8'h00,
    tick_cnt: 16'h0000,
    full_scale: scr_pkg::FS_2G,
    filter: scr_pkg::FILTER_RESET,
    rdata: 8'h00,
    rvalid: 1'b0
  };
  localparam logic [15:0] TICK_LAST = 16'(IDLE_TICK_CYCLES - 1);

  scr_state_t state_reg;
  scr_state_t state_next;
  logic [7:0] cond;
  logic [7:0] rise;
  logic [7:0] clr;
  logic tick;
  logic wake_rise;
  logic aslp_set;
  logic [2:0] axes_now;

  // read strobe decode, used for every read-clear
  function automatic logic rd_at(input scr_pkg::scr_req_t r, input logic [7:0] a);
    rd_at = r.rd && (r.addr == a);
  endfunction

  // mode code as seen in the mode register
  function automatic logic [1:0] mode_code(input scr_pkg::scr_mode_t m);
    case (m)
      scr_pkg::ST_WAKE: mode_code = scr_pkg::MODE_WAKE;
      scr_pkg::ST_SLEEP: mode_code = scr_pkg::MODE_SLEEP;
      default: mode_code = scr_pkg::MODE_STANDBY;
    endcase
  endfunction

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    aslp_set = 1'b0;
    // qualified interrupt conditions, one per source bit except sleep/wake, which is set by aslp_set
    cond = 8'h00;
    cond[scr_pkg::SRC_TRANSIENT_BIT] = events_i.transient_ea && int_en_i.transient;
    cond[scr_pkg::SRC_ORIENT_BIT] = events_i.orientation_changed && int_en_i.orientation;
    cond[scr_pkg::SRC_TAP_BIT] = events_i.tap_ea && int_en_i.tap;
    cond[scr_pkg::SRC_FALL_MOTION_BIT] = events_i.fall_motion_ea && int_en_i.fall_motion;
    cond[scr_pkg::SRC_SAMPLE_READY_BIT] = (events_i.all_axes_ready || events_i.all_axes_overrun)
      && int_en_i.sample_ready;
    rise = cond & ~state_reg.cond_prev;
    wake_rise = events_i.wake_event && !state_reg.wake_prev;
    state_next.cond_prev = cond;
    state_next.wake_prev = events_i.wake_event;

    // idle step divider, runs only while awake
    tick = (state_reg.tick_cnt == TICK_LAST);
    if (state_reg.mode != scr_pkg::ST_WAKE || tick)
    begin
      state_next.tick_cnt = 16'h0000;
    end
    else
    begin
      state_next.tick_cnt = state_reg.tick_cnt + 16'h0001;
    end

    // idle counter restarts on any interrupt; saturates so it never wraps back to idle
    if (state_reg.mode != scr_pkg::ST_WAKE || (|rise) || wake_rise)
    begin
      state_next.idle_cnt = 8'h00;
    end
    else if (tick && state_reg.idle_cnt != 8'hff)
    begin
      state_next.idle_cnt = state_reg.idle_cnt + 8'h01;
    end

    // operating mode machine
    case (state_reg.mode)
      scr_pkg::ST_STANDBY:
      begin
        if (active_i)
        begin
          state_next.mode = scr_pkg::ST_WAKE;
        end
      end
      scr_pkg::ST_WAKE:
      begin
        if (!active_i)
        begin
          state_next.mode = scr_pkg::ST_STANDBY;
        end
        else if (auto_sleep_en_i && state_reg.idle_cnt > sleep_idle_limit_i)
        begin
          state_next.mode = scr_pkg::ST_SLEEP;
          aslp_set = int_en_i.sleep_wake;
        end
      end
      scr_pkg::ST_SLEEP:
      begin
        if (!active_i)
        begin
          state_next.mode = scr_pkg::ST_STANDBY;
        end
        else if (wake_rise)
        begin
          state_next.mode = scr_pkg::ST_WAKE;
          aslp_set = int_en_i.sleep_wake;
        end
      end
      default:
      begin
        state_next.mode = scr_pkg::ST_STANDBY;
      end
    endcase
    state_next.mode_field = mode_code(state_next.mode);
    state_next.low_rate = (state_next.mode == scr_pkg::ST_SLEEP);

    // high-byte reads of each axis; a lone status read does not count
    axes_now = state_reg.axes_read | {rd_at(req_i, scr_pkg::ADDR_Z_HIGH), rd_at(req_i, scr_pkg::ADDR_Y_HIGH),
      rd_at(req_i, scr_pkg::ADDR_X_HIGH)};
    clr = 8'h00;
    clr[scr_pkg::SRC_SLEEP_WAKE_BIT] = rd_at(req_i, scr_pkg::ADDR_SYSTEM_MODE);
    clr[scr_pkg::SRC_TRANSIENT_BIT] = rd_at(req_i, scr_pkg::ADDR_TRANSIENT_SRC);
    clr[scr_pkg::SRC_ORIENT_BIT] = rd_at(req_i, scr_pkg::ADDR_ORIENT_STATUS);
    clr[scr_pkg::SRC_TAP_BIT] = rd_at(req_i, scr_pkg::ADDR_TAP_SRC);
    clr[scr_pkg::SRC_FALL_MOTION_BIT] = rd_at(req_i, scr_pkg::ADDR_FALL_MOTION_SRC);
    clr[scr_pkg::SRC_SAMPLE_READY_BIT] = &axes_now;
    state_next.axes_read = (&axes_now) ? 3'h0 : axes_now;

    // set wins over a read-clear in the same cycle
    state_next.src = ((state_reg.src & ~clr) | rise) & scr_pkg::SRC_USED_MASK;
    if (aslp_set)
    begin
      state_next.src[scr_pkg::SRC_SLEEP_WAKE_BIT] = 1'b1;
    end

    // writes: only the two configuration registers take them
    if (req_i.wr && req_i.addr == scr_pkg::ADDR_RANGE_CONFIG)
    begin
      state_next.full_scale = req_i.wdata[1:0];
    end
    if (req_i.wr && req_i.addr == scr_pkg::ADDR_FILTER_CUTOFF)
    begin
      state_next.filter = req_i.wdata & scr_pkg::FILTER_USED_MASK;
    end

    // read answer, one cycle after the strobe; other addresses belong to other blocks
    state_next.rvalid = req_i.rd;
    if (req_i.rd)
    begin
      case (req_i.addr)
        scr_pkg::ADDR_SYSTEM_MODE: state_next.rdata = {scr_pkg::ZERO_FILL, state_reg.mode_field};
        scr_pkg::ADDR_INT_SOURCE: state_next.rdata = state_reg.src;
        scr_pkg::ADDR_IDENTITY: state_next.rdata = IDENTITY_CODE;
        scr_pkg::ADDR_RANGE_CONFIG: state_next.rdata = {scr_pkg::ZERO_FILL, state_reg.full_scale};
        scr_pkg::ADDR_FILTER_CUTOFF: state_next.rdata = state_reg.filter;
        default: state_next.rdata = scr_pkg::READ_ZERO;
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // synchronous reset gives 2g range and cleared filter bits
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign rdata_o = state_reg.rdata;
  assign rvalid_o = state_reg.rvalid;
  assign mode_o = state_reg.mode_field;
  assign low_rate_sel_o = state_reg.low_rate;
  assign int_source_o = state_reg.src;
  assign full_scale_o = state_reg.full_scale;
  assign tap_hpf_bypass_o = state_reg.filter[scr_pkg::TAP_HPF_BYPASS_BIT];
  assign tap_lpf_en_o = state_reg.filter[scr_pkg::TAP_LPF_ENABLE_BIT];
  assign cutoff_sel_o = state_reg.filter[1:0];

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence idle_exceeded;
    state_reg.mode == scr_pkg::ST_WAKE && active_i && auto_sleep_en_i && state_reg.idle_cnt > sleep_idle_limit_i;
  endsequence

  sequence asleep;
    mode_o == scr_pkg::MODE_SLEEP && low_rate_sel_o;
  endsequence

  mode_read_a:
    assert property (rd_at(req_i, scr_pkg::ADDR_SYSTEM_MODE) |=> rvalid_o
      && rdata_o == {scr_pkg::ZERO_FILL, $past(mode_o)})
    else $error("mode register read wrong");

  src_zero_bits_a:
    assert property ((int_source_o & ~scr_pkg::SRC_USED_MASK) == 8'h00)
    else $error("unused source bit set");

  transient_set_a:
    assert property ($rose(events_i.transient_ea && int_en_i.transient) |=> int_source_o[scr_pkg::SRC_TRANSIENT_BIT])
    else $error("transient flag not set");

  tap_clear_a:
    assert property (rd_at(req_i, scr_pkg::ADDR_TAP_SRC) && !$rose(events_i.tap_ea && int_en_i.tap)
      |=> !int_source_o[scr_pkg::SRC_TAP_BIT])
    else $error("tap flag not cleared by read");

  orient_hold_a:
    assert property (int_source_o[scr_pkg::SRC_ORIENT_BIT] && !rd_at(req_i, scr_pkg::ADDR_ORIENT_STATUS)
      |=> int_source_o[scr_pkg::SRC_ORIENT_BIT])
    else $error("orientation flag lost");

  ready_status_a:
    assert property (int_source_o[scr_pkg::SRC_SAMPLE_READY_BIT] && rd_at(req_i, scr_pkg::ADDR_SAMPLE_STATUS)
      |=> int_source_o[scr_pkg::SRC_SAMPLE_READY_BIT])
    else $error("status read cleared sample ready");

  sleep_entry_a:
    assert property (idle_exceeded |=> asleep ##1 (mode_o == scr_pkg::MODE_SLEEP || !active_i
      || $past(events_i.wake_event && !state_reg.wake_prev)))
    else $error("sleep not entered after idle limit");

  aslp_clear_a:
    assert property (rd_at(req_i, scr_pkg::ADDR_SYSTEM_MODE) && !aslp_set
      |=> !int_source_o[scr_pkg::SRC_SLEEP_WAKE_BIT])
    else $error("sleep/wake flag not cleared by mode read");

  identity_a:
    assert property (rd_at(req_i, scr_pkg::ADDR_IDENTITY) |=> rdata_o == IDENTITY_CODE)
    else $error("identity read wrong");

  range_write_a:
    assert property (req_i.wr && req_i.addr == scr_pkg::ADDR_RANGE_CONFIG |=> full_scale_o == $past(req_i.wdata[1:0]))
    else $error("range write not taken");

  filter_read_a:
    assert property (rd_at(req_i, scr_pkg::ADDR_FILTER_CUTOFF) |=> (rdata_o & ~scr_pkg::FILTER_USED_MASK) == 8'h00)
    else $error("filter zero bits read nonzero");

endmodule

// >>> sim/scr_host_model.sv
// Purpose: host side model that issues single register reads and writes
// Assumes: one access at a time, every request launched on the falling edge
// Notes: released address and data lines show the inverse of the last value

module scr_host_model (
  input wire logic core_clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output scr_pkg::scr_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial req_o = '0;

  // ************************************************************
  // access tasks
  // ************************************************************
  // single write; strobe stands for exactly one sampling edge
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk_i);
    req_o.wr = 1'b1;
    req_o.addr = addr;
    req_o.wdata = data;
    @(negedge core_clk_i);
    req_o.wr = 1'b0;
    req_o.addr = ~addr; // stale lines must never look valid
    req_o.wdata = ~data;
  endtask

  // single read; answer taken under a bounded wait, never open-ended
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge core_clk_i);
    req_o.rd = 1'b1;
    req_o.addr = addr;
    @(negedge core_clk_i);
    req_o.rd = 1'b0;
    req_o.addr = ~addr;
    ok = 1'b0;
    data = 8'h00;
    for (int i = 0; i < 3 && !ok; i++)
    begin
      if (rvalid_i === 1'b1)
      begin
        ok = 1'b1;
        data = rdata_i;
      end
      else
        @(negedge core_clk_i);
    end
  endtask
endmodule

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the status and configuration register bank
// Assumes: idle step shortened to 4 cycles, identity code overridden
// Notes: expected flag image kept in an int and updated from the documented behaviour

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] ID_CODE = 8'ha7; // arbitrary value
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  scr_pkg::scr_req_t req;
  scr_pkg::scr_events_t ev = '0;
  scr_pkg::scr_int_en_t en = '1;
  logic active = 1'b0;
  logic auto_sleep = 1'b0;
  logic [7:0] limit = 8'h02;
  logic [7:0] rdata;
  logic rvalid;
  logic [1:0] mode;
  logic low_rate;
  logic [7:0] src;
  logic [1:0] fs;
  logic hpf_byp;
  logic lpf_en;
  logic [1:0] cutoff;
  int err_count = 0;
  int num_checks = 0;
  int exp_src = 0;
  logic [31:0] seed = 32'h1e0fc9b8;
  logic [7:0] clr_addr [4] = '{scr_pkg::ADDR_TRANSIENT_SRC, scr_pkg::ADDR_ORIENT_STATUS, scr_pkg::ADDR_TAP_SRC,
    scr_pkg::ADDR_FALL_MOTION_SRC};

  // ************************************************************
  // clock, instances
  // ************************************************************
  always #12.5 core_clk = ~core_clk;

  scr_regs #(.IDENTITY_CODE(ID_CODE), .IDLE_TICK_CYCLES(4)) u_scr_regs (
    .core_clk_i(core_clk), .resetn_i(resetn), .req_i(req), .events_i(ev), .int_en_i(en),
    .active_i(active), .auto_sleep_en_i(auto_sleep), .sleep_idle_limit_i(limit),
    .rdata_o(rdata), .rvalid_o(rvalid), .mode_o(mode), .low_rate_sel_o(low_rate),
    .int_source_o(src), .full_scale_o(fs), .tap_hpf_bypass_o(hpf_byp), .tap_lpf_en_o(lpf_en),
    .cutoff_sel_o(cutoff));

  scr_host_model u_scr_host_model (.core_clk_i(core_clk), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // a lost answer is a mismatch and ends the run
  task automatic rd_raw(input logic [7:0] addr, output logic [7:0] d);
    logic ok;
    u_scr_host_model.reg_read(addr, d, ok);
    if (!ok)
    begin
      err_count++;
      finish_test();
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    rd_raw(addr, d);
    chk($sformatf("read %h", addr), d, exp);
  endtask

  task automatic wait_mode(input logic [1:0] m, input int bound);
    for (int i = 0; i < bound && mode !== m; i++)
      @(negedge core_clk);
    chk("mode", {6'h00, mode}, {6'h00, m});
    if (mode !== m)
      finish_test();
  endtask

  // hang guard well above the expected run time
  initial
  begin
    #500us;
    err_count++;
    finish_test();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    logic [31:0] r;
    logic [7:0] d;
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    chk("src", src, 8'h00);
    chk("range", {6'h00, fs}, 8'h00);
    chk("filter", {2'b00, hpf_byp, lpf_en, 2'b00, cutoff}, 8'h00);
    rd_chk(scr_pkg::ADDR_SYSTEM_MODE, 8'h00);
    rd_chk(scr_pkg::ADDR_RANGE_CONFIG, 8'h00);
    rd_chk(scr_pkg::ADDR_FILTER_CUTOFF, 8'h00);
    // read-only places shrug off random writes
    for (int a = 11; a < 14; a++)
    begin
      r = xorshift();
      u_scr_host_model.reg_write(8'(a), r[7:0]);
    end
    rd_chk(scr_pkg::ADDR_SYSTEM_MODE, 8'h00);
    rd_chk(scr_pkg::ADDR_INT_SOURCE, 8'h00);
    rd_chk(scr_pkg::ADDR_IDENTITY, ID_CODE);
    // every range code, junk in the zero-filled bits
    for (int v = 0; v < 4; v++)
    begin
      r = xorshift();
      u_scr_host_model.reg_write(scr_pkg::ADDR_RANGE_CONFIG, {r[7:2], 2'(v)});
      rd_chk(scr_pkg::ADDR_RANGE_CONFIG, {6'h00, 2'(v)});
      chk("range", {6'h00, fs}, {6'h00, 2'(v)});
    end
    for (int n = 0; n < 4; n++)
    begin
      r = xorshift();
      u_scr_host_model.reg_write(scr_pkg::ADDR_FILTER_CUTOFF, r[7:0]);
      rd_chk(scr_pkg::ADDR_FILTER_CUTOFF, r[7:0] & 8'h33);
      chk("filter", {2'b00, hpf_byp, lpf_en, 2'b00, cutoff}, r[7:0] & 8'h33);
    end
    // four detector flags: disabled, set on rise, summary read, own clear
    for (int k = 0; k < 4; k++)
    begin
      en[4-k] = 1'b0;
      ev[6-k] = 1'b1;
      @(negedge core_clk);
      chk("src", src, exp_src[7:0]);
      ev[6-k] = 1'b0;
      @(negedge core_clk);
      en[4-k] = 1'b1;
      ev[6-k] = 1'b1;
      @(negedge core_clk);
      exp_src[5-k] = 1;
      chk("src", src, exp_src[7:0]);
      rd_chk(scr_pkg::ADDR_INT_SOURCE, exp_src[7:0]);
      rd_raw(clr_addr[k], d);
      exp_src[5-k] = 0;
      @(negedge core_clk);
      chk("src", src, exp_src[7:0]);
      ev[6-k] = 1'b0;
    end
    // sample ready: status read alone keeps it, all three high bytes clear it
    for (int k = 0; k < 2; k++)
    begin
      ev[2-k] = 1'b1;
      @(negedge core_clk);
      exp_src[0] = 1;
      chk("src", src, exp_src[7:0]);
      rd_raw(scr_pkg::ADDR_SAMPLE_STATUS, d);
      rd_raw(scr_pkg::ADDR_Z_HIGH, d);
      rd_raw(scr_pkg::ADDR_X_HIGH, d);
      @(negedge core_clk);
      chk("src", src, exp_src[7:0]);
      rd_raw(scr_pkg::ADDR_Y_HIGH, d);
      @(negedge core_clk);
      exp_src[0] = 0;
      chk("src", src, exp_src[7:0]);
      ev[2-k] = 1'b0;
      // ready and overrun share one condition: it must fall before the next source can rise
      @(negedge core_clk);
    end
    // operating modes; the bench follows them on the mode output and checks the mode register
    active = 1'b1;
    wait_mode(scr_pkg::MODE_WAKE, 8);
    rd_chk(scr_pkg::ADDR_SYSTEM_MODE, 8'h01);
    exp_src[7] = 0;
    auto_sleep = 1'b1;
    wait_mode(scr_pkg::MODE_SLEEP, 200);
    @(negedge core_clk);
    exp_src[7] = 1;
    chk("src", src, exp_src[7:0]);
    chk("low rate", {7'h00, low_rate}, 8'h01);
    rd_chk(scr_pkg::ADDR_SYSTEM_MODE, 8'h02);
    exp_src[7] = 0;
    chk("src", src, exp_src[7:0]);
    auto_sleep = 1'b0;
    ev.wake_event = 1'b1;
    wait_mode(scr_pkg::MODE_WAKE, 8);
    @(negedge core_clk);
    exp_src[7] = 1;
    chk("src", src, exp_src[7:0]);
    chk("low rate", {7'h00, low_rate}, 8'h00);
    rd_chk(scr_pkg::ADDR_SYSTEM_MODE, 8'h01);
    ev.wake_event = 1'b0;
    active = 1'b0;
    wait_mode(scr_pkg::MODE_STANDBY, 8);
    finish_test();
  end
endmodule
